// >>> acc_pkg.sv
package acc_pkg;
  localparam int ACC_CONV_NS = 400;
  localparam int ACC_CLK_NS = 5;
  localparam int ACC_CONV_CYC = (ACC_CONV_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;
  localparam int ACC_CAL_NS = 1000;
  localparam int ACC_CAL_CYC = (ACC_CAL_NS + ACC_CLK_NS - 1) / ACC_CLK_NS;
  localparam int ACC_RES_BITS = 16;
  localparam logic [15:0] ACC_RESULT_RST = 16'h0000;
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_CAL = 2'b10
  } acc_state_e;
endpackage

// >>> acc_sync.sv
`timescale 1ns/100ps
module acc_sync (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // pin in, filtered level out
  input wire logic pin_i,
  output logic level_o
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  always_ff @(posedge mclk_i) begin
    s1_q <= pin_i;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end
  // change counts once second and third stages agree
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      level_o <= 1'b1;
    end else if (s2_q == s3_q) begin
      level_o <= s3_q;
    end
  end
endmodule

// >>> acc_conversion_control.sv
`timescale 1ns/100ps
module acc_conversion_control
  import acc_pkg::*;
#(
  parameter int CONV_CYC = ACC_CONV_CYC,
  parameter int CAL_CYC = ACC_CAL_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // host control pins
  input wire logic conversion_start_n_i,
  input wire logic chip_select_n_i,
  input wire logic read_n_i,
  input wire logic power_down_request_i,
  input wire logic ref_powerdown_i,
  input wire logic refbuf_powerdown_i,
  input wire logic clock_source_select_i,
  input wire logic port_style_select_i,
  input wire logic shift_clk_i,
  // converter result from the analog core
  input wire logic [ACC_RES_BITS-1:0] core_result_i,
  // outputs
  output logic busy_o,
  output logic out_bus_en_o,
  output logic serial_result_out_o,
  output logic incomplete_read_flag_o,
  output logic sample_hold_o,
  output logic int_ref_en_o,
  output logic ref_buf_en_o,
  output logic [ACC_RES_BITS-1:0] result_o
);
  logic cnv_s;
  logic cs_s;
  logic rd_s;
  logic pd_s;
  logic sclk_s;
  logic rpd_s;
  logic bpd_s;
  logic clk_sel_s;
  logic port_sel_s;
  logic cnv_prev_q;
  logic sclk_prev_q;
  logic rst_prev_q;
  acc_state_e state_q;
  logic [15:0] cnt_q;
  logic [ACC_RES_BITS-1:0] shreg_q;
  logic [4:0] bits_left_q;
  logic start_edge;
  logic done;
  logic slave_ser;
  logic sclk_rise;

  // every host pin is filtered before use
  acc_sync u_cnv (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(conversion_start_n_i), .level_o(cnv_s));
  acc_sync u_cs (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(chip_select_n_i), .level_o(cs_s));
  acc_sync u_rd (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(read_n_i), .level_o(rd_s));
  acc_sync u_pd (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(power_down_request_i), .level_o(pd_s));
  acc_sync u_sclk (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(shift_clk_i), .level_o(sclk_s));
  acc_sync u_rpd (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(ref_powerdown_i), .level_o(rpd_s));
  acc_sync u_bpd (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(refbuf_powerdown_i), .level_o(bpd_s));
  acc_sync u_csel (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(clock_source_select_i), .level_o(clk_sel_s));
  acc_sync u_psel (.mclk_i(mclk_i), .rst_i(rst_i),
    .pin_i(port_style_select_i), .level_o(port_sel_s));

  assign slave_ser = port_sel_s && clk_sel_s;
  assign start_edge = cnv_prev_q && !cnv_s && !pd_s;
  assign done = (state_q == ACC_CONV) && (cnt_q == 16'(CONV_CYC - 1));
  assign sclk_rise = !sclk_prev_q && sclk_s && !cs_s;

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      cnv_prev_q <= 1'b1;
      // matches the filter's reset level, so no false edge follows reset
      sclk_prev_q <= 1'b1;
      rst_prev_q <= 1'b1;
    end else begin
      cnv_prev_q <= cnv_s;
      sclk_prev_q <= sclk_s;
      rst_prev_q <= 1'b0;
    end
  end

  // conversion and calibration sequencer
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_q <= ACC_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ACC_IDLE: begin
          cnt_q <= 16'h0000;
          if (rst_prev_q) begin
            state_q <= ACC_CAL;
          end else if (start_edge) begin
            state_q <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          cnt_q <= cnt_q + 16'h0001;
          if (done) begin
            state_q <= ACC_IDLE;
          end
        end
        ACC_CAL: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(CAL_CYC - 1)) begin
            state_q <= ACC_IDLE;
          end
        end
        default: state_q <= ACC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
      sample_hold_o <= 1'b0;
    end else begin
      busy_o <= (state_q == ACC_IDLE) ? (rst_prev_q || start_edge) : !(done || (state_q == ACC_CAL
        && cnt_q == 16'(CAL_CYC - 1)));
      // hold only while a real conversion runs, never during calibration
      sample_hold_o <= (state_q == ACC_CONV) ? !done
        : (state_q == ACC_IDLE && !rst_prev_q && start_edge);
    end
  end

  // result latch and serial shifter
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      result_o <= ACC_RESULT_RST;
      shreg_q <= ACC_RESULT_RST;
      bits_left_q <= 5'h00;
      serial_result_out_o <= 1'b0;
      incomplete_read_flag_o <= 1'b0;
    end else begin
      incomplete_read_flag_o <= 1'b0;
      if (done) begin
        result_o <= core_result_i;
        shreg_q <= core_result_i;
        bits_left_q <= 5'(ACC_RES_BITS);
        serial_result_out_o <= core_result_i[ACC_RES_BITS-1];
        if (slave_ser && bits_left_q != 5'h00 && bits_left_q != 5'(ACC_RES_BITS)) begin
          incomplete_read_flag_o <= 1'b1;
        end
      end else if (slave_ser && sclk_rise && bits_left_q != 5'h00) begin
        shreg_q <= {shreg_q[ACC_RES_BITS-2:0], 1'b0};
        serial_result_out_o <= shreg_q[ACC_RES_BITS-2];
        bits_left_q <= bits_left_q - 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      out_bus_en_o <= 1'b0;
      int_ref_en_o <= 1'b1;
      ref_buf_en_o <= 1'b1;
    end else begin
      out_bus_en_o <= !cs_s && !rd_s;
      int_ref_en_o <= !rpd_s;
      ref_buf_en_o <= !bpd_s;
    end
  end

  // sequencer and output checks
  a_bus_enable: assert property (@(posedge mclk_i) disable iff (rst_i)
    out_bus_en_o |-> $past(!cs_s && !rd_s)) else $error("bus enabled without cs and rd");

  a_start_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ACC_IDLE && !rst_prev_q && start_edge) |=> busy_o) else $error("busy missing");

  a_conv_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(state_q == ACC_CONV) |-> (state_q == ACC_CONV)[*8]) else $error("conversion too short");

  a_pd_block: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ACC_IDLE && pd_s && !rst_prev_q) |=> state_q != ACC_CONV) else $error("start in pd");

  a_cal_after: assert property (@(posedge mclk_i)
    $fell(rst_i) |=> ##1 busy_o) else $error("no calibration busy");

  a_reset_idle: assert property (@(posedge mclk_i)
    rst_i |=> (state_q == ACC_IDLE && !busy_o)) else $error("reset did not abort");

  a_rderr_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
    incomplete_read_flag_o |=> !incomplete_read_flag_o) else $error("read error not a pulse");

  a_ref_off: assert property (@(posedge mclk_i) disable iff (rst_i)
    (!rst_prev_q && $past(rpd_s && bpd_s)) |-> (!int_ref_en_o && !ref_buf_en_o)) else $error("reference not off");

  a_cal_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(state_q == ACC_CAL) |-> (state_q == ACC_CAL)[*4]) else $error("calibration too short");

  a_cal_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ACC_CAL) |-> busy_o) else $error("busy low during calibration");

  a_conv_busy: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ACC_CONV) |-> busy_o) else $error("busy low during conversion");

  a_idle_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (state_q == ACC_IDLE) |-> !busy_o) else $error("busy high while idle");

  a_hold_conv: assert property (@(posedge mclk_i) disable iff (rst_i)
    1'b1 |-> (sample_hold_o == (state_q == ACC_CONV))) else $error("hold out of step with conversion");

  a_gate_cs: assert property (@(posedge mclk_i) disable iff (rst_i)
    (cs_s && !done) |=> $stable(bits_left_q)) else $error("shift while deselected");

  a_rderr_done: assert property (@(posedge mclk_i) disable iff (rst_i)
    incomplete_read_flag_o |-> $past(done)) else $error("read error away from completion");

  a_result_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !$past(done) |-> $stable(result_o)) else $error("result changed without completion");
endmodule

// >>> acc_host.sv
`timescale 1ns/100ps
module acc_host (
  // clock
  input wire logic mclk_i,
  // serial pins
  input wire logic serial_result_out_i,
  output logic shift_clk_o,
  output logic chip_select_n_o
);
  logic [15:0] word_q;
  initial begin
    shift_clk_o = 1'b0;
    chip_select_n_o = 1'b1;
  end
  // slow shift clock, so each bit is taken just before its own rising edge
  task automatic shift(input int n, input logic sel_n);
    chip_select_n_o = sel_n;
    repeat (n) begin
      repeat (8) @(negedge mclk_i);
      word_q = {word_q[14:0], serial_result_out_i};
      shift_clk_o = 1'b1;
      repeat (8) @(negedge mclk_i);
      shift_clk_o = 1'b0;
    end
  endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic st_n = 1'b1;
  logic rd_n = 1'b1;
  logic pd = 1'b0;
  logic rpd = 1'b0;
  logic bpd = 1'b0;
  logic [15:0] core = 16'ha5c3;
  logic busy, ben, sdo, rerr, hold, iref, ibuf, sck, cs_n;
  logic [15:0] res;
  int n_fail = 0;
  int samples_checked = 0;
  int n_err = 0;
  int k;
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rerr === 1'b1) n_err++;
  end
  acc_host HOST (.mclk_i(clk), .serial_result_out_i(sdo), .shift_clk_o(sck), .chip_select_n_o(cs_n));
  acc_conversion_control #(.CONV_CYC(12), .CAL_CYC(6)) DUT (.mclk_i(clk), .rst_i(rst),
    .conversion_start_n_i(st_n), .chip_select_n_i(cs_n), .read_n_i(rd_n), .power_down_request_i(pd),
    .ref_powerdown_i(rpd), .refbuf_powerdown_i(bpd), .clock_source_select_i(1'b1),
    .port_style_select_i(1'b1), .shift_clk_i(sck), .core_result_i(core), .busy_o(busy),
    .out_bus_en_o(ben), .serial_result_out_o(sdo), .incomplete_read_flag_o(rerr),
    .sample_hold_o(hold), .int_ref_en_o(iref), .ref_buf_en_o(ibuf), .result_o(res));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("mismatches %0d checks %0d", n_fail, samples_checked);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wait_busy(input logic v);
    for (k = 0; busy !== v && k < 400; k++) @(negedge clk);
    if (k == 400) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic pulse_start();
    st_n = 1'b0;
    repeat (6) @(negedge clk);
    st_n = 1'b1;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    wait_busy(1'b1);
    repeat (3) @(negedge clk);
    check(busy, 1'b1);
    wait_busy(1'b0);
    pulse_start();
    check(hold, 1'b1);
    wait_busy(1'b0);
    check(res, 16'ha5c3);
    HOST.shift(3, 1'b1);
    HOST.shift(16, 1'b0);
    check(HOST.word_q, 16'ha5c3);
    HOST.shift(0, 1'b1);
    core = 16'h3c5a;
    pulse_start();
    wait_busy(1'b0);
    repeat (2) @(negedge clk);
    check(n_err, 0);
    HOST.shift(5, 1'b0);
    pulse_start();
    wait_busy(1'b0);
    repeat (2) @(negedge clk);
    check(n_err, 1);
    HOST.shift(0, 1'b1);
    for (int i = 0; i < 4; i++) begin
      HOST.shift(0, i[0]);
      rd_n = i[1];
      repeat (8) @(negedge clk);
      check(ben, !(i[0] | i[1]));
    end
    // reference goes down first, then the buffer; each enable follows only its own pin
    for (int i = 0; i < 3; i++) begin
      rpd = i > 0;
      bpd = i > 1;
      repeat (8) @(negedge clk);
      check({iref, ibuf}, {!rpd, !bpd});
    end
    core = 16'h0ff1;
    st_n = 1'b0;
    repeat (5) @(negedge clk);
    pd = 1'b1;
    st_n = 1'b1;
    wait_busy(1'b0);
    check(res, 16'h0ff1);
    pulse_start();
    repeat (20) @(negedge clk);
    check(busy, 1'b0);
    pd = 1'b0;
    repeat (6) @(negedge clk);
    pulse_start();
    rst = 1'b1;
    repeat (2) @(negedge clk);
    pulse_start();
    repeat (20) @(negedge clk);
    check(res, 16'h0000);
    rst = 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
    repeat (20) @(negedge clk);
    check(busy, 1'b0);
    summarize();
  end
endmodule
